/* File: design/flash_bus_mode_control.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_bus_mode_control (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_req_valid,
	input wire flash_host_pkg::req_s i_req,
	input wire logic i_bottom_boot,
	output logic o_req_ready,
	output logic o_rdata_valid,
	output logic [15:0] o_rdata,
	output logic [2:0] o_sector,
	output logic o_busy,
	output flash_host_pkg::pins_s o_pins,
	output logic [15:0] o_dq_out,
	output logic [15:0] o_dq_oe,
	input wire logic [15:0] i_dq_in,
	input wire logic i_ready_busy_out
);
	typedef enum logic [2:0] {
		S_IDLE,
		S_SETUP,
		S_STROBE,
		S_RD_WAIT,
		S_RST_LOW,
		S_RST_WAIT,
		S_RECOVER
	} state_e;
	state_e state_reg;
	logic [flash_host_pkg::CNT_W-1:0] cnt_reg;
	flash_host_pkg::req_s req_reg;
	logic [15:0] dq_s1_reg;
	logic [15:0] dq_s2_reg;
	logic rb_s1_reg;
	logic rb_s2_reg;
	logic [2:0] sector_w;

	function automatic logic [7:0] cyc(input int n);
		cyc = 8'(n - 1);
	endfunction

	sector_decode u_dec (
		.i_bottom_boot(i_bottom_boot),
		.i_a16_12(i_req.word_mode ? i_req.addr[16:12] : i_req.addr[17:13]),
		.o_sector(sector_w)
	);

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			dq_s1_reg <= 16'h0000;
			dq_s2_reg <= 16'h0000;
			rb_s1_reg <= 1'b1;
			rb_s2_reg <= 1'b1;
		end else begin
			dq_s1_reg <= i_dq_in;
			dq_s2_reg <= dq_s1_reg;
			rb_s1_reg <= i_ready_busy_out;
			rb_s2_reg <= rb_s1_reg;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= S_IDLE;
			cnt_reg <= 8'h00;
			req_reg <= '0;
			o_sector <= 3'h0;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (i_req_valid) begin
						req_reg <= i_req;
						o_sector <= sector_w;
						cnt_reg <= 8'h00;
						case (i_req.op)
							flash_host_pkg::OP_WRITE: state_reg <= S_SETUP;
							flash_host_pkg::OP_RESET: begin
								state_reg <= S_RST_LOW;
								cnt_reg <= cyc(flash_host_pkg::CYC_RP);
							end
							default: begin
								// unknown op falls back to plain array read
								state_reg <= S_RD_WAIT;
								// access time counted up to the sync output
								cnt_reg <= cyc(flash_host_pkg::CYC_ACCESS + flash_host_pkg::CYC_DQ_SYNC);
							end
						endcase
					end
				end
				S_SETUP: begin
					state_reg <= S_STROBE;
					cnt_reg <= cyc(flash_host_pkg::CYC_WE);
				end
				S_STROBE: begin
					if (cnt_reg == 8'h00) begin
						state_reg <= S_RECOVER;
						cnt_reg <= cyc(flash_host_pkg::CYC_SETUP);
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				S_RD_WAIT: begin
					if (cnt_reg == 8'h00) begin
						state_reg <= S_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				S_RST_LOW: begin
					if (cnt_reg == 8'h00) begin
						state_reg <= S_RST_WAIT;
						cnt_reg <= cyc(flash_host_pkg::CYC_READY_IDLE);
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				S_RST_WAIT: begin
					// wait for ready/busy high and idle ready time
					if (cnt_reg != 8'h00) begin
						cnt_reg <= cnt_reg - 8'h01;
					end else if (rb_s2_reg) begin
						state_reg <= S_RECOVER;
						cnt_reg <= cyc(flash_host_pkg::CYC_RH);
					end
				end
				S_RECOVER: begin
					if (cnt_reg == 8'h00) begin
						state_reg <= S_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// pin drive from state
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_pins <= '{n_ce: 1'b1, n_oe: 1'b1, n_we: 1'b1, n_rst: 1'b1, n_byte: 1'b1,
				addr: 17'h00000};
			o_dq_out <= 16'h0000;
			o_dq_oe <= 16'h0000;
		end else begin
			o_pins.n_byte <= req_reg.word_mode;
			o_pins.addr <= req_reg.word_mode ? req_reg.addr[16:0] : req_reg.addr[17:1];
			o_pins.n_rst <= !(state_reg == S_RST_LOW);
			// chip select only during access, standby otherwise
			o_pins.n_ce <= !(state_reg == S_SETUP || state_reg == S_STROBE ||
				state_reg == S_RD_WAIT);
			o_pins.n_oe <= !(state_reg == S_RD_WAIT);
			o_pins.n_we <= !(state_reg == S_STROBE);
			// data held one cycle past the strobe for hold time
			if (state_reg == S_SETUP || state_reg == S_STROBE ||
				(state_reg == S_RECOVER && req_reg.op == flash_host_pkg::OP_WRITE)) begin
				o_dq_out <= req_reg.wdata;
				if (req_reg.word_mode) begin
					o_dq_oe <= 16'hffff;
				end else begin
					// low byte plus top pin as lsb address
					o_dq_out[15] <= req_reg.addr[0];
					o_dq_oe <= 16'h80ff;
				end
			end else if (state_reg == S_RD_WAIT && !req_reg.word_mode) begin
				o_dq_out <= {req_reg.addr[0], 15'h0000};
				o_dq_oe <= 16'h8000;
			end else begin
				o_dq_out <= 16'h0000;
				o_dq_oe <= 16'h0000;
			end
		end
	end

	// answers: byte mode returns the low byte with the upper byte zeroed
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata_valid <= 1'b0;
			o_rdata <= 16'h0000;
			o_req_ready <= 1'b0;
			o_busy <= 1'b0;
		end else begin
			o_rdata_valid <= (state_reg == S_RD_WAIT) && (cnt_reg == 8'h00);
			if ((state_reg == S_RD_WAIT) && (cnt_reg == 8'h00)) begin
				o_rdata <= req_reg.word_mode ? dq_s2_reg : {8'h00, dq_s2_reg[7:0]};
			end
			o_req_ready <= (state_reg == S_IDLE) && !i_req_valid;
			o_busy <= !rb_s2_reg;
		end
	end
endmodule
`default_nettype wire

/* File: pkg/flash_host_pkg.sv */
package flash_host_pkg;
	localparam int CLK_MHZ = 50;
	localparam int T_ACCESS_NS = 70;
	localparam int T_WE_PULSE_NS = 40;
	localparam int T_SETUP_NS = 20;
	localparam int T_RP_NS = 500;
	localparam int T_RH_NS = 50;
	localparam int T_READY_IDLE_NS = 500;
	localparam int CYC_ACCESS = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_WE = (T_WE_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_SETUP = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_RP = (T_RP_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_RH = (T_RH_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_READY_IDLE = (T_READY_IDLE_NS * CLK_MHZ + 999) / 1000;
	// pin register plus two data sync stages
	localparam int CYC_DQ_SYNC = 3;
	localparam logic [7:0] CNT_W = 8'h08;
	localparam logic [2:0] SEC_TOP_TOP = 3'h6;
	typedef enum logic [1:0] {
		OP_READ,
		OP_WRITE,
		OP_RESET
	} op_e;
	typedef struct packed {
		op_e op;
		logic word_mode;
		logic [17:0] addr;
		logic [15:0] wdata;
	} req_s;
	typedef struct packed {
		logic n_ce;
		logic n_oe;
		logic n_we;
		logic n_rst;
		logic n_byte;
		logic [16:0] addr;
	} pins_s;
endpackage

/* File: design/sector_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module sector_decode (
	input wire logic i_bottom_boot,
	input wire logic [4:0] i_a16_12,
	output logic [2:0] o_sector
);
	// sector index from high address bits
	always_comb begin
		o_sector = 3'h0;
		if (!i_bottom_boot) begin
			casez (i_a16_12)
				5'b00???: o_sector = 3'h0;
				5'b01???: o_sector = 3'h1;
				5'b10???: o_sector = 3'h2;
				5'b110??: o_sector = 3'h3;
				5'b11100: o_sector = 3'h4;
				5'b11101: o_sector = 3'h5;
				default: o_sector = flash_host_pkg::SEC_TOP_TOP;
			endcase
		end else begin
			casez (i_a16_12)
				5'b0000?: o_sector = 3'h0;
				5'b00010: o_sector = 3'h1;
				5'b00011: o_sector = 3'h2;
				5'b001??: o_sector = 3'h3;
				5'b01???: o_sector = 3'h4;
				5'b10???: o_sector = 3'h5;
				default: o_sector = flash_host_pkg::SEC_TOP_TOP;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: sim/flash_bus_mode_control_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_bus_mode_control_asserts (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic o_rdata_valid,
	input wire flash_host_pkg::pins_s o_pins,
	input wire logic [15:0] o_dq_oe
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	sequence read_held;
		(!o_pins.n_oe && !o_pins.n_ce)[*6];
	endsequence
	sequence write_lanes;
		o_dq_oe == (o_pins.n_byte ? 16'hffff : 16'h80ff);
	endsequence
	sequence read_lanes;
		o_dq_oe == (o_pins.n_byte ? 16'h0000 : 16'h8000) && o_pins.n_we;
	endsequence
	a_write_qual: assert property (!o_pins.n_we |-> !o_pins.n_ce && o_pins.n_oe)
		else $error("write strobe without select");
	a_write_lanes: assert property (!o_pins.n_we |-> write_lanes)
		else $error("write lanes wrong");
	a_read_release: assert property (!o_pins.n_oe |-> read_lanes)
		else $error("bus driven during read");
	a_access_wait: assert property ($fell(o_pins.n_oe) |-> read_held ##[1:2] o_rdata_valid)
		else $error("read access too short");
	a_reset_recovery: assert property ($rose(o_pins.n_rst) |-> o_pins.n_oe[*3])
		else $error("read too soon after reset");
endmodule
bind flash_bus_mode_control flash_bus_mode_control_asserts u_asserts (.i_clk_sys(i_clk_sys),
	.i_nrst(i_nrst), .o_rdata_valid(o_rdata_valid), .o_pins(o_pins), .o_dq_oe(o_dq_oe));
`default_nettype wire

/* File: sim/flash_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
	input wire logic i_clk,
	input wire flash_host_pkg::pins_s i_pins,
	input wire logic [15:0] i_dq,
	output logic [15:0] o_dq,
	output logic o_rb
);
	logic [15:0] mem [32];
	logic [15:0] wd;
	logic [15:0] rv;
	logic [15:0] last = 16'h0000;
	logic [4:0] wa;
	logic pw = 1'b1;
	logic wq = 1'b0;
	logic wl;
	int busy = 0;
	int acc = 0;
	wire logic rd = !i_pins.n_ce && !i_pins.n_oe && i_pins.n_we && i_pins.n_rst;
	wire logic ok = rd && acc >= flash_host_pkg::CYC_ACCESS - 1;
	assign rv = busy != 0 ? {8'h00, ~mem[i_pins.addr[4:0]][7:0]} : mem[i_pins.addr[4:0]];
	assign o_dq = ok ? (i_pins.n_byte ? rv : {8'h00, i_dq[15] ? rv[15:8] : rv[7:0]}) : ~last;
	assign o_rb = busy == 0;
	always @(posedge i_clk) begin
		pw <= i_pins.n_we;
		if (!i_pins.n_we) begin
			wd <= i_dq;
			wa <= i_pins.addr[4:0];
			wl <= i_dq[15];
			wq <= !i_pins.n_ce && i_pins.n_oe && i_pins.n_rst;
		end
		acc <= rd ? acc + 1 : 0;
		if (ok)
			last <= o_dq;
		if (!i_pins.n_rst && busy > 20)
			busy <= 20; // abort, busy held until internal reset ends
		else if (busy > 0)
			busy <= busy - 1; // runs on while deselected
		if (i_pins.n_we && !pw && wq && i_pins.n_rst && busy == 0) begin
			busy <= 30;
			if (i_pins.n_byte)
				mem[wa] <= wd;
			else if (wl)
				mem[wa][15:8] <= wd[7:0];
			else
				mem[wa][7:0] <= wd[7:0];
		end
	end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct packed {logic bb; logic w; logic [17:0] a; logic [15:0] d; logic [2:0] s;} row_s;
	logic i_clk_sys = 1'b0;
	logic i_nrst = 1'b0;
	logic i_req_valid = 1'b0;
	flash_host_pkg::req_s i_req = '0;
	logic i_bottom_boot = 1'b0;
	logic o_req_ready, o_rdata_valid, o_busy, rb;
	logic [15:0] o_rdata, o_dq_out, o_dq_oe, dev_dq;
	logic [2:0] o_sector;
	flash_host_pkg::pins_s o_pins;
	int miscompares = 0;
	int checks_done = 0;
	row_s rows [6] = '{'{1'b0, 1'b1, 18'h1e003, 16'h1234, 3'h6},
		'{1'b0, 1'b1, 18'h1c005, 16'hbeef, 3'h4}, '{1'b1, 1'b1, 18'h03007, 16'h0ff0, 3'h2},
		'{1'b1, 1'b0, 18'h1000b, 16'h00c3, 3'h4}, '{1'b0, 1'b0, 18'h3a009, 16'h003c, 3'h5},
		'{1'b1, 1'b1, 18'h00001, 16'h8001, 3'h0}};
	wire logic [15:0] dq_wire = (o_dq_oe & o_dq_out) | (~o_dq_oe & dev_dq);
	always #10 i_clk_sys = ~i_clk_sys;
	flash_bus_mode_control u_flash_bus_mode_control (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
		.i_req_valid(i_req_valid), .i_req(i_req), .i_bottom_boot(i_bottom_boot),
		.o_req_ready(o_req_ready), .o_rdata_valid(o_rdata_valid), .o_rdata(o_rdata),
		.o_sector(o_sector), .o_busy(o_busy), .o_pins(o_pins), .o_dq_out(o_dq_out),
		.o_dq_oe(o_dq_oe), .i_dq_in(dq_wire), .i_ready_busy_out(rb));
	flash_dev_model u_flash_dev_model (.i_clk(i_clk_sys), .i_pins(o_pins), .i_dq(dq_wire),
		.o_dq(dev_dq), .o_rb(rb));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task req(input flash_host_pkg::op_e op, input logic w, input logic [17:0] a, input logic [15:0] d);
		for (int n = 0; n < 200 && o_req_ready !== 1'b1; n++)
			@(negedge i_clk_sys);
		chk({15'h0000, o_req_ready}, 16'h0001);
		@(posedge i_clk_sys);
		i_req_valid <= 1'b1;
		i_req <= '{op, w, a, d};
		@(posedge i_clk_sys);
		i_req_valid <= 1'b0;
		repeat (2) @(negedge i_clk_sys);
	endtask
	task wbusy(input logic v);
		for (int n = 0; n < 100 && o_busy !== v; n++)
			@(negedge i_clk_sys);
		chk({15'h0000, o_busy}, {15'h0000, v});
	endtask
	task rd(input logic w, input logic [17:0] a, input logic [15:0] e);
		req(flash_host_pkg::OP_READ, w, a, 16'h0000);
		for (int n = 0; n < 20 && o_rdata_valid !== 1'b1; n++)
			@(negedge i_clk_sys);
		chk({15'h0000, o_rdata_valid}, 16'h0001);
		chk(o_rdata, e);
	endtask
	task wr(input logic w, input logic [17:0] a, input logic [15:0] d);
		req(flash_host_pkg::OP_WRITE, w, a, d);
		wbusy(1'b1);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge i_clk_sys);
		i_nrst <= 1'b1;
		@(negedge i_clk_sys);
		chk({o_dq_oe[14:0], o_pins.n_ce}, 16'h0001);
		$display("reset test done");
		foreach (rows[i]) begin
			@(posedge i_clk_sys);
			i_bottom_boot <= rows[i].bb;
			wr(rows[i].w, rows[i].a, rows[i].d);
			wbusy(1'b0);
			rd(rows[i].w, rows[i].a, rows[i].w ? rows[i].d : {8'h00, rows[i].d[7:0]});
			chk({13'h0000, o_sector}, {13'h0000, rows[i].s});
		end
		$display("table test done");
		wr(1'b1, 18'h00011, 16'h5aa5);
		rd(1'b1, 18'h00011, 16'h005a);
		wbusy(1'b0);
		wr(1'b1, 18'h00012, 16'h0f0f);
		req(flash_host_pkg::OP_RESET, 1'b1, 18'h00000, 16'h0000);
		chk({15'h0000, o_busy}, 16'h0001);
		rd(1'b1, 18'h00012, 16'h0f0f);
		chk({15'h0000, o_busy}, 16'h0000);
		wr(1'b1, 18'h00012, 16'h0f0f);
		wbusy(1'b0);
		rd(1'b1, 18'h00012, 16'h0f0f);
		$display("hand test done");
		end_of_test;
	end
	initial begin
		#200000;
		miscompares++;
		end_of_test;
	end
endmodule
`default_nettype wire
